// File: rtl/anim_ctrl_pkg.sv
// Package: register map, field layout, reset values and timing constants of the animation player.
//
// Function
// - Blink-suppress bit kills all LED blinking.
// - Scroll sequence rests on first/last frame.
// - Length field n plays n+1 frames, at most 36.
// - Hold code times 32.5ms; zero plays once.
// - Fade between frames, not in blocks.
// - Direction bit: zero right, one left.
// - Group bit: full matrix or five-LED blocks.
// - Scroll enable scrolls during playback only.
// - Repeat code sets loops; 111 endless.
// - Host rewrite of repeat stops endless play.
// - Period bit selects 1.5s or 3s.
// - Segment count limits scan to lines 0..n.
// - Twelve segments refresh near 430Hz.
// - Drive level maps linearly to current.
// - Reset values 0x20 and 0x00.
// - Separate start index begins sequence.
package anim_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ANIMATION_MODE_CTRL = 8'h02;
    localparam logic [7:0] ADDR_FRAME_HOLD_SCROLL_CTRL = 8'h03;
    localparam logic [7:0] ADDR_LOOP_BLINK_SCAN_CTRL = 8'h04;
    localparam logic [7:0] ADDR_LED_DRIVE_LEVEL = 8'h05;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ANIMATION_MODE_CTRL = 8'h00;
    localparam logic [7:0] RST_FRAME_HOLD_SCROLL_CTRL = 8'h00;
    localparam logic [7:0] RST_LOOP_BLINK_SCAN_CTRL = 8'h20;
    localparam logic [7:0] RST_LED_DRIVE_LEVEL = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_BLINK_OFF = 7;
    localparam int BIT_STOP_ON_FINAL = 6;
    localparam int BIT_FADE = 7;
    localparam int BIT_SHIFT_LEFT = 6;
    localparam int BIT_BLOCK_GROUP = 5;
    localparam int BIT_SCROLL_EN = 4;
    localparam int BIT_LONG_BLINK = 4;
    localparam logic [2:0] REPEAT_ENDLESS = 3'h7;
    localparam logic [3:0] HOLD_ONCE = 4'h0;
    localparam logic [5:0] MAX_SEQ_LAST = 6'h23;
    localparam logic [3:0] MAX_SEG_LAST = 4'hb;

    // ------------------------------------------------------------------
    // Timing, at a 100 MHz system clock
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam longint HOLD_STEP_PS = 64'd32500000000;
    localparam int HOLD_STEP_CYC = int'(HOLD_STEP_PS / CLK_PERIOD_PS);
    localparam longint BLINK_SHORT_PS = 64'd1500000000000;
    localparam int BLINK_HALF_CYC = int'(BLINK_SHORT_PS / CLK_PERIOD_PS / 2);
    localparam int REFRESH_HZ = 430;
    localparam int SEG_SLOT_CYC = 100000000 / (REFRESH_HZ * 12);

    // Decoded control view handed between processes.
    typedef struct packed {
        logic blink_off;
        logic stop_on_final;
        logic [5:0] seq_last;
        logic fade;
        logic shift_left;
        logic block_group;
        logic scroll_en;
        logic [3:0] hold_code;
        logic [2:0] repeat_code;
        logic long_blink;
        logic [3:0] seg_last;
    } ctrl_s;

endpackage

// File: rtl/led_matrix_movie_scroll_ctrl.sv
// Animation player: control registers, frame sequencing, scrolling, blinking and scan.
`timescale 1ns/100ps
`default_nettype none

module led_matrix_movie_scroll_ctrl #(
    parameter int HOLD_STEP_CYC = anim_ctrl_pkg::HOLD_STEP_CYC,
    parameter int BLINK_HALF_CYC = anim_ctrl_pkg::BLINK_HALF_CYC,
    parameter int SEG_SLOT_CYC = anim_ctrl_pkg::SEG_SLOT_CYC
) (
    // Clock, reset, enable.
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    input wire logic I_CLK_EN,
    // Register port from the serial interface logic.
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    output logic [7:0] O_REG_RDATA,
    // Sequence start from the neighbouring start register.
    input wire logic I_SEQ_START,
    input wire logic [5:0] I_SEQ_FIRST,
    // Display drive.
    output logic O_PLAYING,
    output logic [5:0] O_FRAME,
    output logic O_SHIFT_STEP,
    output logic O_SHIFT_LEFT,
    output logic O_BLOCK_GROUP,
    output logic O_FADE,
    output logic O_BLINK_PHASE,
    output logic O_BLINK_OFF,
    output logic [3:0] O_COLUMN_SOURCE_LINE,
    output logic O_SEG_STROBE,
    output logic [7:0] O_DRIVE_LEVEL
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] animation_mode_ctrl; // Blink off, stop-on-final, length.
    logic [7:0] frame_hold_scroll_ctrl; // Fade, scroll options, hold code.
    logic [7:0] loop_blink_scan_ctrl; // Repeat, blink period, segment count.
    logic [7:0] led_drive_level; // Analog drive level.
    anim_ctrl_pkg::ctrl_s ctrl; // Decoded fields.

    // Field decode is plain wiring.
    always_comb begin
        ctrl.blink_off = animation_mode_ctrl[anim_ctrl_pkg::BIT_BLINK_OFF];
        ctrl.stop_on_final = animation_mode_ctrl[anim_ctrl_pkg::BIT_STOP_ON_FINAL];
        ctrl.seq_last = animation_mode_ctrl[5:0];
        ctrl.fade = frame_hold_scroll_ctrl[anim_ctrl_pkg::BIT_FADE];
        ctrl.shift_left = frame_hold_scroll_ctrl[anim_ctrl_pkg::BIT_SHIFT_LEFT];
        ctrl.block_group = frame_hold_scroll_ctrl[anim_ctrl_pkg::BIT_BLOCK_GROUP];
        ctrl.scroll_en = frame_hold_scroll_ctrl[anim_ctrl_pkg::BIT_SCROLL_EN];
        ctrl.hold_code = frame_hold_scroll_ctrl[3:0];
        ctrl.repeat_code = loop_blink_scan_ctrl[7:5];
        ctrl.long_blink = loop_blink_scan_ctrl[anim_ctrl_pkg::BIT_LONG_BLINK];
        ctrl.seg_last = loop_blink_scan_ctrl[3:0];
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Writes to other offsets belong to neighbouring blocks and are ignored here.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            animation_mode_ctrl <= anim_ctrl_pkg::RST_ANIMATION_MODE_CTRL;
            frame_hold_scroll_ctrl <= anim_ctrl_pkg::RST_FRAME_HOLD_SCROLL_CTRL;
            loop_blink_scan_ctrl <= anim_ctrl_pkg::RST_LOOP_BLINK_SCAN_CTRL;
            led_drive_level <= anim_ctrl_pkg::RST_LED_DRIVE_LEVEL;
        end else if (I_CLK_EN && I_REG_WR) begin
            if (I_REG_ADDR == anim_ctrl_pkg::ADDR_ANIMATION_MODE_CTRL) begin
                animation_mode_ctrl <= I_REG_WDATA;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_FRAME_HOLD_SCROLL_CTRL) begin
                frame_hold_scroll_ctrl <= I_REG_WDATA;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_LOOP_BLINK_SCAN_CTRL) begin
                loop_blink_scan_ctrl <= I_REG_WDATA;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_LED_DRIVE_LEVEL) begin
                led_drive_level <= I_REG_WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Read data is registered; unmapped offsets read as zero.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_REG_RDATA <= 8'h00;
        end else if (I_CLK_EN) begin
            if (I_REG_ADDR == anim_ctrl_pkg::ADDR_ANIMATION_MODE_CTRL) begin
                O_REG_RDATA <= animation_mode_ctrl;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_FRAME_HOLD_SCROLL_CTRL) begin
                O_REG_RDATA <= frame_hold_scroll_ctrl;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_LOOP_BLINK_SCAN_CTRL) begin
                O_REG_RDATA <= loop_blink_scan_ctrl;
            end else if (I_REG_ADDR == anim_ctrl_pkg::ADDR_LED_DRIVE_LEVEL) begin
                O_REG_RDATA <= led_drive_level;
            end else begin
                O_REG_RDATA <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame hold timer
    // ------------------------------------------------------------------
    logic [23:0] step_cnt; // Cycles within one 32.5 ms step.
    logic [3:0] hold_cnt; // Steps elapsed for the current frame.
    logic hold_done; // Current frame has shown long enough.
    logic [5:0] seq_len_m1; // Frames minus one, clamped to the memory size.
    logic step_tick;

    assign step_tick = (step_cnt == 24'(HOLD_STEP_CYC - 1));
    // Code zero shows each frame for one step, so the sequence still advances once.
    assign hold_done = step_tick &&
        ((ctrl.hold_code == anim_ctrl_pkg::HOLD_ONCE) || (hold_cnt == ctrl.hold_code - 4'h1));
    assign seq_len_m1 = (ctrl.seq_last > anim_ctrl_pkg::MAX_SEQ_LAST) ?
        anim_ctrl_pkg::MAX_SEQ_LAST : ctrl.seq_last;

    // The timer counts only while a sequence plays and restarts on each frame.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            step_cnt <= 24'h000000;
            hold_cnt <= 4'h0;
        end else if (I_CLK_EN) begin
            if (!O_PLAYING || I_SEQ_START) begin
                step_cnt <= 24'h000000;
                hold_cnt <= 4'h0;
            end else if (step_tick) begin
                step_cnt <= 24'h000000;
                hold_cnt <= hold_done ? 4'h0 : hold_cnt + 4'h1;
            end else begin
                step_cnt <= step_cnt + 24'h000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequence player
    // ------------------------------------------------------------------
    logic [5:0] frame_idx; // Offset of the shown frame within the sequence.
    logic [2:0] loops_done; // Loops completed so far.
    logic last_frame;

    assign last_frame = (frame_idx == seq_len_m1);

    // A loop ends at the last frame; endless play rechecks the live repeat code,
    // so rewriting it to a finite code stops playback at the first loop end where loops_done + 1 is not below that code.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PLAYING <= 1'b0;
            frame_idx <= 6'h00;
            loops_done <= 3'h0;
            O_FRAME <= 6'h00;
            O_SHIFT_STEP <= 1'b0;
        end else if (I_CLK_EN) begin
            O_SHIFT_STEP <= 1'b0;
            if (I_SEQ_START) begin
                O_PLAYING <= 1'b1;
                frame_idx <= 6'h00;
                loops_done <= 3'h0;
                O_FRAME <= I_SEQ_FIRST;
            end else if (O_PLAYING && hold_done) begin
                O_SHIFT_STEP <= ctrl.scroll_en;
                if (!last_frame) begin
                    frame_idx <= frame_idx + 6'h01;
                    O_FRAME <= O_FRAME + 6'h01;
                end else if (ctrl.repeat_code == anim_ctrl_pkg::REPEAT_ENDLESS ||
                             loops_done + 3'h1 < ctrl.repeat_code) begin
                    loops_done <= loops_done + 3'h1;
                    frame_idx <= 6'h00;
                    O_FRAME <= O_FRAME - seq_len_m1;
                end else begin
                    O_PLAYING <= 1'b0;
                    // A scrolled sequence rests on its first or last frame.
                    if (ctrl.scroll_en && !ctrl.stop_on_final) begin
                        O_FRAME <= O_FRAME - seq_len_m1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Scroll and fade controls
    // ------------------------------------------------------------------
    // Fade is forced off in block mode since the split sources cannot cross-fade.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_SHIFT_LEFT <= 1'b0;
            O_BLOCK_GROUP <= 1'b0;
            O_FADE <= 1'b0;
        end else if (I_CLK_EN) begin
            O_SHIFT_LEFT <= ctrl.shift_left;
            O_BLOCK_GROUP <= ctrl.block_group;
            O_FADE <= ctrl.fade && !ctrl.block_group && O_PLAYING;
        end
    end

    // ------------------------------------------------------------------
    // Blink timebase
    // ------------------------------------------------------------------
    logic [27:0] blink_cnt; // Cycles in the current blink half period.

    // The long period doubles the half-period count rather than using a second counter.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            blink_cnt <= 28'h0000000;
            O_BLINK_PHASE <= 1'b0;
            O_BLINK_OFF <= 1'b0;
        end else if (I_CLK_EN) begin
            O_BLINK_OFF <= ctrl.blink_off;
            if (ctrl.blink_off) begin
                blink_cnt <= 28'h0000000;
                O_BLINK_PHASE <= 1'b0;
            end else if (blink_cnt >= (ctrl.long_blink ? 28'(2 * BLINK_HALF_CYC - 1) :
                                        28'(BLINK_HALF_CYC - 1))) begin
                blink_cnt <= 28'h0000000;
                O_BLINK_PHASE <= !O_BLINK_PHASE;
            end else begin
                blink_cnt <= blink_cnt + 28'h0000001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Segment scan
    // ------------------------------------------------------------------
    logic [19:0] slot_cnt; // Cycles within one segment slot.

    // Fixed slot time: fewer segments means a shorter full pass, hence faster refresh.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            slot_cnt <= 20'h00000;
            O_COLUMN_SOURCE_LINE <= 4'h0;
            O_SEG_STROBE <= 1'b0;
        end else if (I_CLK_EN) begin
            O_SEG_STROBE <= 1'b0;
            if (slot_cnt == 20'(SEG_SLOT_CYC - 1)) begin
                slot_cnt <= 20'h00000;
                O_SEG_STROBE <= 1'b1;
                if (O_COLUMN_SOURCE_LINE >= ctrl.seg_last ||
                    O_COLUMN_SOURCE_LINE >= anim_ctrl_pkg::MAX_SEG_LAST) begin
                    O_COLUMN_SOURCE_LINE <= 4'h0;
                end else begin
                    O_COLUMN_SOURCE_LINE <= O_COLUMN_SOURCE_LINE + 4'h1;
                end
            end else begin
                slot_cnt <= slot_cnt + 20'h00001;
            end
        end
    end

    // ------------------------------------------------------------------
    // Drive level
    // ------------------------------------------------------------------
    // The analog DAC converts this code linearly; zero gives no current.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_DRIVE_LEVEL <= 8'h00;
        end else if (I_CLK_EN) begin
            O_DRIVE_LEVEL <= led_drive_level;
        end
    end

endmodule
`default_nettype wire

// File: tb/anim_host_model.sv
// Host model that programs the player through its register port.
`timescale 1ns/100ps
`default_nettype none
module anim_host_model (
    // Clock.
    input wire logic clk,
    // Register port.
    output logic wr,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    // Idle port at time zero.
    initial begin
        wr = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // One strobe per byte; released data shows the inverse so a stale byte is never mistaken.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask
    // Address held two edges, answer taken once settled.
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        @(posedge clk);
        @(negedge clk);
        d = rdata;
    endtask
    // Endless scrolling needs endless loops and rest-on-first; scrolling is switched on with a one-step hold.
    task automatic endless_scroll(input logic [5:0] n);
        wr_reg(8'h03, 8'h11);
        wr_reg(8'h02, {2'b00, n});
        wr_reg(8'h04, 8'he2);
    endtask
    // Endless play is halted by rewriting the loop field below endless.
    task automatic halt_endless;
        wr_reg(8'h04, 8'h22);
    endtask
endmodule
`default_nettype wire

// File: tb/anim_ctrl_props.sv
// Port checker of the animation player.
`timescale 1ns/100ps
`default_nettype none
module anim_ctrl_props (
    // Clock and reset.
    input wire logic I_SYS_CLK,
    input wire logic I_RST_B,
    // Inputs.
    input wire logic I_CLK_EN,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_SEQ_START,
    input wire logic [5:0] I_SEQ_FIRST,
    // Outputs.
    input wire logic O_PLAYING,
    input wire logic [5:0] O_FRAME,
    input wire logic O_SHIFT_STEP,
    input wire logic O_SHIFT_LEFT,
    input wire logic O_BLOCK_GROUP,
    input wire logic O_FADE,
    input wire logic O_BLINK_PHASE,
    input wire logic O_BLINK_OFF,
    input wire logic [3:0] O_COLUMN_SOURCE_LINE,
    input wire logic O_SEG_STROBE,
    input wire logic [7:0] O_DRIVE_LEVEL
);
    logic [7:0] mode_sh; // Last accepted mode byte.
    logic [7:0] hold_sh; // Last accepted hold and scroll byte.
    logic [7:0] drv_sh; // Last accepted drive byte.
    logic [1:0] quiet; // Cycles since any write; copies are only judged once settled.
    // Shadows follow accepted writes only.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            mode_sh <= 8'h00;
            hold_sh <= 8'h00;
            drv_sh <= 8'h00;
        end else if (I_REG_WR && I_CLK_EN) begin
            if (I_REG_ADDR == 8'h02) mode_sh <= I_REG_WDATA;
            if (I_REG_ADDR == 8'h03) hold_sh <= I_REG_WDATA;
            if (I_REG_ADDR == 8'h05) drv_sh <= I_REG_WDATA;
        end
    end
    // Settling counter, restarted by every strobe.
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) quiet <= 2'h0;
        else if (I_REG_WR) quiet <= 2'h0;
        else if (quiet != 2'h3) quiet <= quiet + 2'h1;
    end
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);
    // A taken start shows the first frame on the next cycle.
    sequence s_start;
        I_SEQ_START && I_CLK_EN;
    endsequence
    sequence s_shown;
        O_PLAYING && (O_FRAME == $past(I_SEQ_FIRST));
    endsequence
    a_start_frame: assert property (s_start |=> s_shown)
        else $error("start frame not shown");
    a_drive_level: assert property (quiet == 2'h3 |-> O_DRIVE_LEVEL == drv_sh)
        else $error("drive level differs");
    a_shift_bits: assert property (quiet == 2'h3 |-> {O_SHIFT_LEFT, O_BLOCK_GROUP} == hold_sh[6:5])
        else $error("scroll bits differ");
    a_blink_copy: assert property (quiet == 2'h3 |-> O_BLINK_OFF == mode_sh[7])
        else $error("blink suppress differs");
    a_blink_held: assert property (O_BLINK_OFF && $past(O_BLINK_OFF) |-> !O_BLINK_PHASE)
        else $error("blink while suppressed");
    a_fade_block: assert property (O_BLOCK_GROUP && $past(O_BLOCK_GROUP) |-> !O_FADE)
        else $error("fade in block mode");
    a_fade_copy: assert property (quiet == 2'h3 |->
        O_FADE == (hold_sh[7] && !hold_sh[5] && $past(O_PLAYING)))
        else $error("fade control differs");
    a_scan_range: assert property (O_COLUMN_SOURCE_LINE <= 4'hb)
        else $error("scan line out of range");
    a_strobe_slot: assert property (O_SEG_STROBE |=> !O_SEG_STROBE [*3])
        else $error("segment slot too short");
    a_step_scroll: assert property (O_SHIFT_STEP && quiet == 2'h3 |-> hold_sh[4] && !$past(O_SHIFT_STEP))
        else $error("shift step without scroll");
endmodule
`default_nettype wire

// File: tb/led_matrix_movie_scroll_ctrl_tb.sv
// Self-checking testbench of the animation player.
`timescale 1ns/100ps
`default_nettype none
module led_matrix_movie_scroll_ctrl_tb;
    // --------------------------------------------------------------
    // Signals, clock and instances
    // --------------------------------------------------------------
    logic clk, rst_b, clk_en, seq_start, wr, playing, step, sleft, bgrp, fade, bph, boff, sstb;
    logic [7:0] addr, wdata, rdata, drv, d;
    logic [5:0] seq_first, frame;
    logic [3:0] line;
    int fails, checks_done, chg, stp, g, t;
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    led_matrix_movie_scroll_ctrl #(.HOLD_STEP_CYC(10), .BLINK_HALF_CYC(20), .SEG_SLOT_CYC(4))
    i_led_matrix_movie_scroll_ctrl (.I_SYS_CLK(clk), .I_RST_B(rst_b), .I_CLK_EN(clk_en), .I_REG_WR(wr),
        .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_SEQ_START(seq_start),
        .I_SEQ_FIRST(seq_first), .O_PLAYING(playing), .O_FRAME(frame), .O_SHIFT_STEP(step), .O_SHIFT_LEFT(sleft),
        .O_BLOCK_GROUP(bgrp), .O_FADE(fade), .O_BLINK_PHASE(bph), .O_BLINK_OFF(boff),
        .O_COLUMN_SOURCE_LINE(line), .O_SEG_STROBE(sstb), .O_DRIVE_LEVEL(drv));
    anim_host_model i_anim_host_model (.clk(clk), .wr(wr), .addr(addr), .wdata(wdata), .rdata(rdata));
    // Compare, count and report at once.
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // The single place where the run ends.
    task automatic end_sim;
        if (fails == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Expected rest frame: scroll without stop-on-final returns to the first frame.
    function automatic logic [7:0] exp_rest(input int first, input int n, input logic scr, input logic endl);
        return (scr && !endl) ? first : first + n;
    endfunction
    // Highest scanned line for a segment count; anything above eleven scans all twelve.
    function automatic logic [7:0] exp_line(input logic [3:0] n);
        return (n > 4'hb) ? 8'h0b : {4'h0, n};
    endfunction
    // Pulse a sequence start.
    task automatic start(input logic [5:0] first);
        @(posedge clk);
        seq_first <= first;
        seq_start <= 1'b1;
        @(posedge clk);
        seq_start <= 1'b0;
    endtask
    // Follow play to its end, checking each frame and hold gap; bounded.
    task automatic watch(input int first, input int n, input int hold);
        int k, gap, idx;
        logic [5:0] last;
        // Align to the frame actually shown, which need not be the first one.
        @(negedge clk);
        last = frame;
        gap = -1;
        idx = int'(frame) - first;
        chg = 0;
        stp = 0;
        for (k = 0; k < 4000 && (k < 3 || playing); k++) begin
            @(negedge clk);
            if (gap >= 0) gap++;
            stp += int'(step);
            if (playing && frame !== last) begin
                idx = (idx + 1) % (n + 1);
                chk("frame", first + idx, frame);
                if (gap > 0) chk("hold_gap", (hold == 0) ? 10 : hold * 10, gap);
                gap = 0;
                chg++;
                last = frame;
            end
        end
        if (k == 4000) begin
            fails++;
            end_sim();
        end
    endtask
    // Cycles between two blink toggles; bounded.
    task automatic blink_gap(output int n);
        logic p;
        n = 0;
        @(negedge clk);
        p = bph;
        while (bph === p && n < 300) @(negedge clk) n++;
        p = bph;
        n = 0;
        while (bph === p && n < 300) @(negedge clk) n++;
        if (n >= 300) begin
            fails++;
            end_sim();
        end
    endtask
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        static logic [7:0] ra[6] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h00};
        static logic [7:0] rv[6] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00};
        int f, n, h, lp, sc, el, hi;
        logic [3:0] sl;
        rst_b = 1'b0;
        clk_en = 1'b1;
        seq_start = 1'b0;
        seq_first = 6'h00;
        fails = 0;
        checks_done = 0;
        void'($urandom(31));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            i_anim_host_model.rd_reg(ra[i], d);
            chk("reset_value", rv[i], d);
        end
        for (int i = 0; i < 6; i++) begin
            f = $urandom_range(0, 255);
            i_anim_host_model.wr_reg(ra[i], f[7:0]);
            i_anim_host_model.rd_reg(ra[i], d);
            chk("read_back", (i < 4) ? f[7:0] : 8'h00, d);
            if (i == 3) chk("drive_out", f[7:0], drv);
        end
        // Random plays plus the full 36-frame corner.
        for (int t2 = 0; t2 < 7; t2++) begin
            f = (t2 == 0) ? 0 : $urandom_range(0, 28);
            n = (t2 == 0) ? 35 : $urandom_range(0, 5);
            h = $urandom_range(0, 3);
            lp = $urandom_range(1, 3);
            sc = $urandom_range(0, 1);
            el = $urandom_range(0, 1);
            i_anim_host_model.wr_reg(8'h02, {1'b0, el[0], n[5:0]});
            i_anim_host_model.wr_reg(8'h03, {3'($urandom_range(0, 7)), sc[0], h[3:0]});
            i_anim_host_model.wr_reg(8'h04, {lp[2:0], 5'h02});
            start(f[5:0]);
            watch(f, n, h);
            // A single-frame sequence never shows a visible frame change.
            chk("changes", (n == 0) ? 0 : lp * (n + 1) - 1, chg);
            chk("scroll_steps", sc, stp != 0);
            chk("rest_frame", exp_rest(f, n, sc[0], el[0]), frame);
        end
        // Endless scroll runs until the loop field is rewritten.
        i_anim_host_model.endless_scroll(6'h02);
        start(6'h05);
        repeat (300) @(negedge clk);
        chk("endless", 1, playing);
        i_anim_host_model.halt_endless();
        watch(5, 2, 1);
        chk("halted", 0, playing);
        chk("rest_first", 8'h05, frame);
        // Blink period short and long, then suppression.
        for (int b = 0; b < 2; b++) begin
            i_anim_host_model.wr_reg(8'h02, 8'h00);
            i_anim_host_model.wr_reg(8'h04, b ? 8'h32 : 8'h22);
            blink_gap(g);
            chk("blink_half", b ? 40 : 20, g);
        end
        i_anim_host_model.wr_reg(8'h02, 8'h80);
        // The phase is cleared one edge after the write lands.
        repeat (2) @(posedge clk);
        hi = 0;
        repeat (100) @(negedge clk) hi += int'(bph);
        chk("blink_off", 0, hi);
        // Scan limit and refresh slots.
        for (t = 0; t < 4; t++) begin
            sl = (t == 0) ? 4'hf : 4'($urandom_range(1, 11));
            i_anim_host_model.wr_reg(8'h04, {4'h2, sl});
            repeat (60) @(posedge clk);
            hi = 0;
            g = 0;
            repeat (100) @(negedge clk) begin
                if (line > hi) hi = line;
                g += int'(sstb);
            end
            chk("scan_top", exp_line(sl), hi);
            chk("slots", 25, g);
        end
        end_sim();
    end
endmodule
bind led_matrix_movie_scroll_ctrl anim_ctrl_props i_anim_ctrl_props (.I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B),
    .I_CLK_EN(I_CLK_EN), .I_REG_WR(I_REG_WR), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_SEQ_START(I_SEQ_START), .I_SEQ_FIRST(I_SEQ_FIRST), .O_PLAYING(O_PLAYING), .O_FRAME(O_FRAME),
    .O_SHIFT_STEP(O_SHIFT_STEP), .O_SHIFT_LEFT(O_SHIFT_LEFT), .O_BLOCK_GROUP(O_BLOCK_GROUP), .O_FADE(O_FADE),
    .O_BLINK_PHASE(O_BLINK_PHASE), .O_BLINK_OFF(O_BLINK_OFF), .O_COLUMN_SOURCE_LINE(O_COLUMN_SOURCE_LINE),
    .O_SEG_STROBE(O_SEG_STROBE), .O_DRIVE_LEVEL(O_DRIVE_LEVEL));
`default_nettype wire
